// file: logic/reset_ctl.sv
// Reset cause tracking, brown-out control and reset sequencing
// Behaviour
// - Top bit selects interrupt priority levels
// - Software brown-out bit works only mode 01
// - Software brown-out bit resets to one in 01
// - Reset-instruction flag clears on that reset
// - Timeout flag set by clear/sleep, cleared by timeout
// - Power-down flag set by clear, cleared sleep
// - Power-on flag cleared by power-on or a software write
// - Brown-out flag cleared on brown-out/power-on
// - Low clear pin resets, short pulses filtered
// - Clear pin is never driven low
// - Disabled clear pin is plain input
// - Power-on pulse resets the device
// - Brown-out off in mode 00, minimum duration
// - Held in reset until supply recovers
// - Power-up timer restarts after each brown-out
// - Brown-out and power-up timer enables independent
// - Trip level only from configuration bits
// - Mode 10 disables brown-out during sleep
// - Mode 11 brown-out always on
// - Power-up timer counts 2048 slow cycles
`timescale 1ns/1ns
module reset_ctl
    import reset_ctl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    // Register port
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Configuration bits
    input  wire logic [1:0] brownout_config_mode,
    input  wire logic [1:0] brownout_threshold_select,
    input  wire logic       ext_clear_pin_enable,
    input  wire logic       powerup_timer_enable,
    // Analog and pin inputs
    input  wire logic       power_on_pulse,
    input  wire logic       supply_below_bor,
    input  wire logic       ext_clear_pin,
    input  wire logic       low_freq_internal_osc,
    // Core events
    input  wire logic       reset_instruction,
    input  wire logic       watchdog_timeout,
    input  wire logic       watchdog_clear_instruction,
    input  wire logic       sleep_instruction,
    input  wire logic       in_sleep,
    // Outputs
    output logic            device_reset,
    output logic            irq_level_enable,
    output logic            brownout_detect_enable,
    output logic      [1:0] brownout_trip_select,
    output logic            ext_clear_pin_oe,
    output logic            ext_clear_pin_out,
    output logic            ext_clear_pin_data
);
    import reset_ctl_pkg::*;

    // Synchroniser stages for asynchronous inputs
    logic [1:0] por_sync;
    logic [1:0] bor_sync;
    logic [1:0] clr_sync;
    logic [1:0] osc_sync;
    logic       osc_prev;

    logic       sw_brownout_enable;
    logic       reset_instruction_flag;
    logic       watchdog_timeout_flag;
    logic       power_down_flag;
    logic       power_on_flag;
    logic       brownout_flag;

    logic [3:0]            clr_cnt;
    logic                  clr_filtered;
    logic [7:0]            bor_cnt;
    logic                  bor_trip;
    logic [POWERUP_TIMER_WIDTH-1:0] powerup_timer_cnt;
    logic [1:0]            release_cnt;
    rst_state_t            state;
    logic                  por_seen;
    logic                  bor_active;
    logic                  osc_tick;
    logic                  reset_source;
    logic                  rinst_pending;
    logic                  wdt_pending;
    logic [7:0]            ctrl_value;

    // Two flops on every pin-side input; only the second stage is read
    // Power-on stage resets high so every release of rst_b is seen as a power-on
    // Clear-pin stage resets to the pin's idle level, so no false clear follows
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            por_sync <= 2'h3;
            bor_sync <= 2'h0;
            clr_sync <= 2'h3;
            osc_sync <= 2'h0;
            osc_prev <= 1'b0;
        end else if (clk_en) begin
            por_sync <= {por_sync[0], power_on_pulse};
            bor_sync <= {bor_sync[0], supply_below_bor};
            clr_sync <= {clr_sync[0], ext_clear_pin};
            osc_sync <= {osc_sync[0], low_freq_internal_osc};
            osc_prev <= osc_sync[1];
        end
    end

    // Rising edge of the slow oscillator; it runs free, so only edges are counted
    assign osc_tick = osc_sync[1] & ~osc_prev;

    assign ext_clear_pin_oe  = 1'b0;
    assign ext_clear_pin_out = 1'b0;
    assign ext_clear_pin_data = clr_sync[1];
    assign brownout_trip_select = brownout_threshold_select;

    always_comb begin
        unique case (brownout_config_mode)
            BOR_MODE_OFF:   bor_active = 1'b0;
            BOR_MODE_SW:    bor_active = sw_brownout_enable;
            BOR_MODE_SLEEP: bor_active = ~in_sleep;
            BOR_MODE_ON:    bor_active = 1'b1;
        endcase
    end
    assign brownout_detect_enable = bor_active;

    // noise filter on clear pin
    // A pulse shorter than the filter count never reaches the reset sources
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            clr_cnt      <= 4'h0;
            clr_filtered <= 1'b0;
        end else if (clk_en) begin
            if (clr_sync[1] || !ext_clear_pin_enable) begin
                clr_cnt      <= 4'h0;
                clr_filtered <= 1'b0;
            end else if (clr_cnt >= FILTER_CYC) begin
                clr_filtered <= 1'b1;
            end else begin
                clr_cnt <= clr_cnt + 4'h1;
            end
        end
    end

    // drop must last minimum duration
    // Leaving the enabled modes drops a pending trip at once
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bor_cnt  <= 8'h0;
            bor_trip <= 1'b0;
        end else if (clk_en) begin
            if (!bor_sync[1] || !bor_active) begin
                bor_cnt  <= 8'h0;
                bor_trip <= 1'b0;
            end else if (bor_cnt >= BOR_MIN_CYC) begin
                bor_trip <= 1'b1;
            end else begin
                bor_cnt <= bor_cnt + 8'h1;
            end
        end
    end

    // Any asynchronous or core reset cause
    // power-on pulse resets
    assign reset_source = por_sync[1] | bor_trip | clr_filtered
                        | reset_instruction | watchdog_timeout;

    // Reset sequencer with power-up timer
    // Flag por_seen remembers a power-on or brown-out cause across the held state
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state       <= ST_HELD;
            powerup_timer_cnt    <= '0;
            release_cnt <= 2'h0;
            por_seen    <= 1'b1;
        end else if (clk_en) begin
            unique case (state)
                ST_HELD: begin
                    powerup_timer_cnt <= '0;
                    if (!reset_source) begin
                        // timer has its own enable
                        // Only power-on or brown-out causes earn the timer delay
                        if (powerup_timer_enable && por_seen) begin
                            state <= ST_POWERUP_TIMER;
                        end else begin
                            state <= ST_RUN;
                        end
                        release_cnt <= RELEASE_CYC;
                    end
                end
                ST_POWERUP_TIMER: begin
                    if (reset_source) begin
                        state    <= ST_HELD;
                        powerup_timer_cnt <= '0;
                    end else if (osc_tick) begin
                        if (powerup_timer_cnt == POWERUP_TIMER_LAST) begin
                            state <= ST_RUN;
                        end
                        powerup_timer_cnt <= powerup_timer_cnt + 11'h1;
                    end
                end
                ST_RUN: begin
                    por_seen <= 1'b0;
                    if (reset_source) begin
                        state <= ST_HELD;
                        por_seen <= por_sync[1] | bor_trip;
                    end else if (release_cnt != 2'h0) begin
                        release_cnt <= release_cnt - 2'h1;
                    end
                end
                default: state <= ST_HELD;
            endcase
        end
    end

    // registered, stretched release
    // Source term keeps a new cause from waiting a cycle for the state machine
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            device_reset <= 1'b1;
        end else if (clk_en) begin
            device_reset <= (state != ST_RUN) || (release_cnt != 2'h0) || reset_source;
        end
    end

    // Remember which core reset is in progress
    // Flags clear one cycle after the event, while the core is already held
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rinst_pending <= 1'b0;
            wdt_pending   <= 1'b0;
        end else if (clk_en) begin
            rinst_pending <= reset_instruction;
            wdt_pending   <= watchdog_timeout;
        end
    end

    // Control bits; power-on wins over software writes
    // Writes made while a power-on pulse is pending are lost by design
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_level_enable   <= 1'b0;
            sw_brownout_enable <= 1'b1;
        end else if (clk_en) begin
            if (por_sync[1]) begin
                irq_level_enable   <= 1'b0;
                sw_brownout_enable <= (brownout_config_mode == BOR_MODE_SW);
            end else if (reg_wr && reg_addr == ADDR_RESET_CTRL) begin
                irq_level_enable   <= reg_wdata[BIT_IRQ_LEVEL];
                sw_brownout_enable <= reg_wdata[BIT_SW_BOR];
            end
        end
    end

    // Reset-cause flags; hardware events beat software writes
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_instruction_flag <= 1'b1;
            watchdog_timeout_flag  <= 1'b1;
            power_down_flag        <= 1'b1;
            power_on_flag          <= 1'b0;
            brownout_flag          <= 1'b0;
        end else if (clk_en) begin
            if (rinst_pending) begin
                reset_instruction_flag <= 1'b0;
            end else if (por_sync[1]) begin
                reset_instruction_flag <= 1'b1;
            end else if (reg_wr && reg_addr == ADDR_RESET_CTRL) begin
                reset_instruction_flag <= reg_wdata[BIT_RESET_INST];
            end
            if (wdt_pending) begin
                watchdog_timeout_flag <= 1'b0;
            end else if (por_sync[1] || watchdog_clear_instruction || sleep_instruction) begin
                watchdog_timeout_flag <= 1'b1;
            end
            if (sleep_instruction) begin
                power_down_flag <= 1'b0;
            end else if (por_sync[1] || watchdog_clear_instruction) begin
                power_down_flag <= 1'b1;
            end
            if (por_sync[1]) begin
                power_on_flag <= 1'b0;
            end else if (reg_wr && reg_addr == ADDR_RESET_CTRL) begin
                power_on_flag <= reg_wdata[BIT_POWER_ON];
            end
            if (por_sync[1] || bor_trip) begin
                brownout_flag <= 1'b0;
            end else if (reg_wr && reg_addr == ADDR_RESET_CTRL) begin
                brownout_flag <= reg_wdata[BIT_BROWNOUT];
            end
        end
    end

    // bit reads zero outside mode 01
    // Bit 5 is unused and reads zero
    always_comb begin
        ctrl_value = 8'h00;
        ctrl_value[BIT_IRQ_LEVEL]  = irq_level_enable;
        ctrl_value[BIT_SW_BOR]     = sw_brownout_enable && (brownout_config_mode == BOR_MODE_SW);
        ctrl_value[BIT_RESET_INST] = reset_instruction_flag;
        ctrl_value[BIT_WDT_TO]     = watchdog_timeout_flag;
        ctrl_value[BIT_PWR_DOWN]   = power_down_flag;
        ctrl_value[BIT_POWER_ON]   = power_on_flag;
        ctrl_value[BIT_BROWNOUT]   = brownout_flag;
    end

    // Read data one cycle after strobe; unmapped reads zero
    // Address 1 returns the one-hot sequencer state for bring-up
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (reg_rd && reg_addr == ADDR_RESET_CTRL) begin
                reg_rdata <= ctrl_value;
            end else if (reg_rd && reg_addr == ADDR_RESET_INFO) begin
                reg_rdata <= {5'h00, state};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end
endmodule // reset_ctl

// file: logic/reset_ctl_pkg.sv
// Package: register layout, config encodings and timing counts for the reset controller
package reset_ctl_pkg;
    // Register map (plain port, byte-wide register)
    localparam logic [1:0] ADDR_RESET_CTRL = 2'h0;
    localparam logic [1:0] ADDR_RESET_INFO = 2'h1;
    // Field positions of the reset control register
    localparam int BIT_IRQ_LEVEL  = 7;
    localparam int BIT_SW_BOR     = 6;
    localparam int BIT_RESET_INST = 4;
    localparam int BIT_WDT_TO     = 3;
    localparam int BIT_PWR_DOWN   = 2;
    localparam int BIT_POWER_ON   = 1;
    localparam int BIT_BROWNOUT   = 0;
    // Brown-out configuration modes
    localparam logic [1:0] BOR_MODE_OFF   = 2'h0;
    localparam logic [1:0] BOR_MODE_SW    = 2'h1;
    localparam logic [1:0] BOR_MODE_SLEEP = 2'h2;
    localparam logic [1:0] BOR_MODE_ON    = 2'h3;
    // Power-up timer: 11-bit count of slow oscillator cycles
    localparam int          POWERUP_TIMER_WIDTH  = 11;
    localparam logic [10:0] POWERUP_TIMER_LAST   = 11'h7ff;
    // Noise filter on the external clear pin
    localparam int          FILTER_NS   = 20;
    localparam int          CLK_NS      = 4;
    localparam logic [3:0]  FILTER_CYC  = 4'((FILTER_NS + CLK_NS - 1) / CLK_NS);
    // Minimum brown-out duration before it resets
    localparam int          BOR_MIN_NS  = 200;
    localparam logic [7:0]  BOR_MIN_CYC = 8'((BOR_MIN_NS + CLK_NS - 1) / CLK_NS);
    // Reset release stretch after all sources clear
    localparam logic [1:0]  RELEASE_CYC = 2'h3;
    // Reset state machine
    typedef enum logic [2:0] {
        ST_HELD = 3'b001,
        ST_POWERUP_TIMER = 3'b010,
        ST_RUN  = 3'b100
    } rst_state_t;
endpackage

// file: sim/reset_ctl_assertions.sv
// Checker: port-level properties of the reset controller
`timescale 1ns/1ns
module reset_ctl_assertions
    import reset_ctl_pkg::*;
(
    // Clock and register port
    input wire logic       sys_clk,
    input wire logic       rst_b,
    input wire logic       clk_en,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Configuration and sources
    input wire logic [1:0] brownout_config_mode,
    input wire logic [1:0] brownout_threshold_select,
    input wire logic       ext_clear_pin_enable,
    input wire logic       power_on_pulse,
    input wire logic       supply_below_bor,
    input wire logic       ext_clear_pin,
    input wire logic       watchdog_timeout,
    input wire logic       watchdog_clear_instruction,
    input wire logic       sleep_instruction,
    input wire logic       in_sleep,
    // Outputs
    input wire logic       device_reset,
    input wire logic       irq_level_enable,
    input wire logic       brownout_detect_enable,
    input wire logic [1:0] brownout_trip_select,
    input wire logic       ext_clear_pin_oe,
    input wire logic       ext_clear_pin_out
);
    logic [7:0] dip_cnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // Length of an enabled supply dip; saturates, and pauses while the design is frozen
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dip_cnt <= 8'h00;
        end else if (!(supply_below_bor && brownout_detect_enable)) begin
            dip_cnt <= 8'h00;
        end else if (clk_en && dip_cnt != 8'hff) begin
            dip_cnt <= dip_cnt + 8'h01;
        end
    end
    // Steps of the core and register traffic
    sequence s_sleep;
        sleep_instruction && clk_en && !watchdog_clear_instruction && !watchdog_timeout;
    endsequence
    sequence s_rd_ctrl;
        reg_rd && clk_en && reg_addr == ADDR_RESET_CTRL;
    endsequence
    sequence s_wr_ctrl;
        reg_wr && clk_en && reg_addr == ADDR_RESET_CTRL;
    endsequence
    a_pin_never_driven: assert property (!ext_clear_pin_oe && !ext_clear_pin_out)
        else $error("clear pin driven");
    a_trip_from_config: assert property (brownout_trip_select == brownout_threshold_select)
        else $error("trip level not from config");
    a_irq_bit_write: assert property (!power_on_pulse [*4] ##0 s_wr_ctrl |=>
        irq_level_enable == $past(reg_wdata[BIT_IRQ_LEVEL])) else $error("irq bit not written");
    a_bor_mode_enable: assert property (brownout_config_mode != BOR_MODE_SW |->
        brownout_detect_enable == (brownout_config_mode == BOR_MODE_ON
        || (brownout_config_mode == BOR_MODE_SLEEP && !in_sleep))) else $error("detector enable");
    a_rdata_idle_zero: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_sw_bit_hidden: assert property (s_rd_ctrl ##0 brownout_config_mode != BOR_MODE_SW |=>
        !reg_rdata[BIT_SW_BOR]) else $error("software enable bit visible");
    a_sleep_sets_flags: assert property (!watchdog_timeout ##1 s_sleep
        ##1 !watchdog_clear_instruction ##1 s_rd_ctrl |=>
        !reg_rdata[BIT_PWR_DOWN] && reg_rdata[BIT_WDT_TO]) else $error("sleep flags");
    a_clear_forces_reset: assert property ((ext_clear_pin_enable && !ext_clear_pin && clk_en) [*8]
        |->
        ##[0:4] device_reset) else $error("held clear pin gave no reset");
    a_por_forces_reset: assert property ((power_on_pulse && clk_en) [*4] |-> ##[0:3] device_reset)
        else $error("power-on pulse gave no reset");
    a_dip_holds_reset: assert property (dip_cnt >= 8'h3c |-> device_reset)
        else $error("brown-out not held in reset");
endmodule // reset_ctl_assertions

bind reset_ctl reset_ctl_assertions u_reset_ctl_assertions (.*);

// file: sim/tb_top.sv
// Testbench: register and reset-source scenarios for the reset controller
`timescale 1ns/1ns
module tb_top;
    import reset_ctl_pkg::*;
    logic       sys_clk   = 1'b0;
    logic       rst_b     = 1'b0;
    logic       clk_en    = 1'b1;
    logic [1:0] reg_addr  = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [1:0] mode      = BOR_MODE_SW;
    logic [1:0] thr       = 2'h0;
    logic       pin_en    = 1'b1;
    logic       powerup_timer_en   = 1'b0;
    logic       por       = 1'b0;
    logic       dip       = 1'b0;
    logic       pin       = 1'b1;
    logic       osc       = 1'b0;
    logic       sleeping  = 1'b0;
    logic [3:0] evs       = 4'h0;
    logic [7:0] reg_rdata;
    logic [1:0] trip;
    logic       device_reset, irq_on, bor_en, pin_data;
    int         n_fail    = 0;
    int         cmp_count = 0;
    int         n;
    // Clocks: slow oscillator is 4 device cycles long
    always #2 sys_clk = ~sys_clk;
    always #8 osc = ~osc;
    // Device under test
    reset_ctl u_reset_ctl (.sys_clk, .rst_b, .clk_en, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .brownout_config_mode(mode),
        .brownout_threshold_select(thr), .ext_clear_pin_enable(pin_en),
        .powerup_timer_enable(powerup_timer_en), .power_on_pulse(por), .supply_below_bor(dip),
        .ext_clear_pin(pin), .low_freq_internal_osc(osc), .reset_instruction(evs[0]),
        .watchdog_timeout(evs[1]), .watchdog_clear_instruction(evs[2]),
        .sleep_instruction(evs[3]), .in_sleep(sleeping), .device_reset,
        .irq_level_enable(irq_on), .brownout_detect_enable(bor_en),
        .brownout_trip_select(trip), .ext_clear_pin_oe(), .ext_clear_pin_out(),
        .ext_clear_pin_data(pin_data));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Register cycles; read data is taken only in the answer cycle
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // One-cycle core event pulse
    task automatic ev(input int k);
        @(posedge sys_clk);
        evs[k] <= 1'b1;
        @(posedge sys_clk);
        evs[k] <= 1'b0;
    endtask
    // Bounded wait for a reset level; running out ends the run
    task automatic wait_rst(input logic v, input int lim);
        n = 0;
        while (device_reset !== v && n < lim) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n >= lim) begin
            chk(8'h01, 8'h00);
            final_report();
        end
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    // Main sequence
    initial begin
        idle(5);
        rst_b <= 1'b1;
        wait_rst(1'b0, 200);
        rd(ADDR_RESET_CTRL, 8'h5c);
        wr(ADDR_RESET_CTRL, 8'hff);
        rd(ADDR_RESET_CTRL, 8'hdf);
        chk(8'(irq_on), 8'h01);
        wr(ADDR_RESET_INFO, 8'h00);
        rd(2'h3, 8'h00);
        wr(ADDR_RESET_CTRL, 8'h00);
        rd(ADDR_RESET_CTRL, 8'h0c);
        chk(8'(irq_on), 8'h00);
        chk(8'(bor_en), 8'h00);
        wr(ADDR_RESET_CTRL, 8'hff);
        #1 chk(8'(bor_en), 8'h01);
        $display("test registers done");
        ev(0);
        wait_rst(1'b1, 20);
        wait_rst(1'b0, 200);
        rd(ADDR_RESET_CTRL, 8'hcf);
        ev(1);
        wait_rst(1'b1, 20);
        wait_rst(1'b0, 200);
        rd(ADDR_RESET_CTRL, 8'hc7);
        ev(2);
        rd(ADDR_RESET_CTRL, 8'hcf);
        ev(3);
        rd(ADDR_RESET_CTRL, 8'hcb);
        $display("test events done");
        // Software mode first, so its stored bit is seen before other modes
        for (int m = 1; m < 5; m++) begin
            mode <= 2'(m);
            thr <= 2'(4 - m);
            sleeping <= 1'b1;
            rd(ADDR_RESET_CTRL, (m == 1) ? 8'hcb : 8'h8b);
            chk(8'(bor_en), 8'(m % 2));
            sleeping <= 1'b0;
            idle(1);
            #1 chk(8'(bor_en), (m == 4) ? 8'h00 : 8'h01);
            chk(8'(trip), 8'(4 - m));
        end
        $display("test modes done");
        mode <= BOR_MODE_ON;
        powerup_timer_en <= 1'b1;
        ev(2);
        dip <= 1'b1;
        idle(80);
        #1 chk(8'(device_reset), 8'h01);
        dip <= 1'b0;
        idle(2000);
        #1 chk(8'(device_reset), 8'h01);
        dip <= 1'b1;
        idle(80);
        dip <= 1'b0;
        wait_rst(1'b0, 12000);
        chk(8'(n >= 8180), 8'h01);
        chk(8'(n <= 8220), 8'h01);
        rd(ADDR_RESET_CTRL, 8'h8e);
        powerup_timer_en <= 1'b0;
        dip <= 1'b1;
        idle(80);
        dip <= 1'b0;
        wait_rst(1'b0, 40);
        $display("test brownout done");
        pin <= 1'b0;
        idle(2);
        pin <= 1'b1;
        idle(15);
        #1 chk(8'(device_reset), 8'h00);
        pin <= 1'b0;
        idle(20);
        #1 chk(8'(device_reset), 8'h01);
        pin <= 1'b1;
        wait_rst(1'b0, 40);
        pin_en <= 1'b0;
        pin <= 1'b0;
        idle(20);
        #1 chk(8'(device_reset), 8'h00);
        chk(8'(pin_data), 8'h00);
        pin <= 1'b1;
        $display("test clear pin done");
        por <= 1'b1;
        idle(10);
        #1 chk(8'(device_reset), 8'h01);
        por <= 1'b0;
        wait_rst(1'b0, 40);
        rd(ADDR_RESET_CTRL, 8'h1c);
        mode <= BOR_MODE_SW;
        rd(ADDR_RESET_CTRL, 8'h1c);
        wr(ADDR_RESET_CTRL, 8'h13);
        rd(ADDR_RESET_CTRL, 8'h1f);
        $display("test power-on done");
        // A write while the enable is low must leave the register alone
        clk_en <= 1'b0;
        wr(ADDR_RESET_CTRL, 8'h80);
        clk_en <= 1'b1;
        chk(8'(irq_on), 8'h00);
        rd(ADDR_RESET_CTRL, 8'h1f);
        $display("test clock enable done");
        final_report();
    end
endmodule // tb_top
